//--- inc/sptp_pkg.sv
// Package for the serial port and test pattern select block
package sptp_pkg;
    // ****************************************
    // Serial frame and control register
    // ****************************************
    localparam int FRAME_BITS = 24;
    localparam int ADDR_POS = 16;
    localparam int ADDR_W = 4;
    localparam int RD_POS = 23;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int PATTERN_BIT = 12;
    localparam int TP_LEN = 4;
    localparam logic [11:0] TP_WORD0 = 12'h000;
    localparam logic [11:0] TP_WORD1 = 12'hfff;
    localparam logic [11:0] TP_WORD2 = 12'h555;
    localparam logic [11:0] TP_WORD3 = 12'haaa;

    typedef struct packed {
        logic sclk;
        logic serial_select_n;
        logic serial_in_line;
        logic extended_control_enable_n;
        logic test_pattern_select;
    } sptp_pins_type;
endpackage : sptp_pkg

//--- core/sptp_core.sv
// Serial configuration port and test pattern output logic
`timescale 1ns/10ps
`default_nettype none

// Contract
// - In extended mode shift serial input bits only while select is low.
// - In extended mode shift output bits only while select is low.
// - Serial output is high impedance whenever select is high.
// - Outside extended mode, pattern pin high drives repeating pattern on outputs.
// - In extended mode pattern pin ignored; control bit 12 enables pattern.
// - Host drives shift clock; bits move on its edges; it may idle low.
// - Serial input is ignored while select is high.
// - Enable pin low enables port; high disables it and resets the control register.
module sptp_core #(
    parameter int DATA_W = 12
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire sptp_pkg::sptp_pins_type pins,
    input wire logic [DATA_W-1:0] conv_data,
    output logic serial_out_line,
    output logic serial_out_oe_n,
    output logic [DATA_W-1:0] data_out,
    output logic pattern_active,
    output logic [15:0] ctrl_reg_out
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    sptp_pkg::sptp_pins_type s1_reg, s2_reg, s3_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    logic ext_mode;
    logic sel;
    logic rise;
    logic fall;
    assign ext_mode = !s2_reg.extended_control_enable_n;
    assign sel = ext_mode && !s2_reg.serial_select_n;
    // Edges found from sampled clock, so link clock must be slow
    assign rise = s2_reg.sclk && !s3_reg.sclk;
    assign fall = !s2_reg.sclk && s3_reg.sclk;

    // ****************************************
    // Shift engine
    // ****************************************
    logic [4:0] cnt_reg, cnt_next;
    logic [23:0] sh_reg, sh_next;
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] out_sh_reg, out_sh_next;
    logic sout_reg, sout_next;
    logic oe_n_reg, oe_n_next;

    // Readback loads after the address bits, ahead of the data bits
    localparam logic [4:0] LOAD_AT =
        5'(sptp_pkg::FRAME_BITS - sptp_pkg::ADDR_POS - 1);
    localparam logic [4:0] LAST_AT = 5'(sptp_pkg::FRAME_BITS - 1);
    // Frame bit n sits one place lower in the shift word at the last rise
    localparam int ADDR_TOP = sptp_pkg::ADDR_POS + 2;

    always_comb begin
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        ctrl_next = ctrl_reg;
        out_sh_next = out_sh_reg;
        sout_next = sout_reg;
        oe_n_next = 1'b1;
        if (!ext_mode) begin
            ctrl_next = sptp_pkg::CTRL_RESET;
            cnt_next = '0;
            sout_next = 1'b0;
        end else if (!sel) begin
            // Deselect aborts a cut frame
            cnt_next = '0;
            sout_next = 1'b0;
        end else begin
            oe_n_next = 1'b0;
            if (rise) begin
                sh_next = {sh_reg[22:0], s2_reg.serial_in_line};
                cnt_next = cnt_reg + 5'd1;
                if (cnt_reg == LOAD_AT) begin
                    out_sh_next = ctrl_reg;
                end
                if (cnt_reg == LAST_AT) begin
                    cnt_next = '0;
                    if (!sh_reg[sptp_pkg::RD_POS - 1] &&
                        sh_reg[ADDR_TOP -: sptp_pkg::ADDR_W]
                        == sptp_pkg::CTRL_ADDR) begin
                        ctrl_next = {sh_reg[14:0], s2_reg.serial_in_line};
                    end
                end
            end
            // Sixteen falls after the load carry the sixteen data bits
            if (fall && cnt_reg > LOAD_AT) begin
                sout_next = out_sh_reg[15];
                out_sh_next = {out_sh_reg[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            sh_reg <= '0;
            ctrl_reg <= sptp_pkg::CTRL_RESET;
            out_sh_reg <= '0;
            sout_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            ctrl_reg <= ctrl_next;
            out_sh_reg <= out_sh_next;
            sout_reg <= sout_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ****************************************
    // Test pattern
    // ****************************************
    logic tp_en;
    logic [1:0] tp_idx_reg, tp_idx_next;
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic tp_reg, tp_next;
    logic [11:0] tp_word;

    // Pattern restarts from the first word on every entry
    assign tp_en = ext_mode ? ctrl_reg[sptp_pkg::PATTERN_BIT]
                            : s2_reg.test_pattern_select;

    always_comb begin
        tp_word = sptp_pkg::TP_WORD0;
        case (tp_idx_reg)
            2'h0: tp_word = sptp_pkg::TP_WORD0;
            2'h1: tp_word = sptp_pkg::TP_WORD1;
            2'h2: tp_word = sptp_pkg::TP_WORD2;
            2'h3: tp_word = sptp_pkg::TP_WORD3;
            default: tp_word = sptp_pkg::TP_WORD0;
        endcase
        tp_next = tp_en;
        tp_idx_next = tp_en ? tp_idx_reg + 2'h1 : 2'h0;
        dout_next = tp_en ? DATA_W'(tp_word) : conv_data;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tp_idx_reg <= 2'h0;
            dout_reg <= '0;
            tp_reg <= 1'b0;
        end else begin
            tp_idx_reg <= tp_idx_next;
            dout_reg <= dout_next;
            tp_reg <= tp_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every pin comes straight from a flop, so no glitch reaches it
    assign serial_out_line = sout_reg;
    assign serial_out_oe_n = oe_n_reg;
    assign data_out = dout_reg;
    assign pattern_active = tp_reg;
    assign ctrl_reg_out = ctrl_reg;

    // ****************************************
    // Serial port checks
    // ****************************************
    chk_oe_high_sel: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s2_reg.serial_select_n |=> serial_out_oe_n)
        else $error("serial output driven while select high");
    chk_ctrl_reset: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s2_reg.extended_control_enable_n |=>
        ctrl_reg_out == sptp_pkg::CTRL_RESET)
        else $error("control not reset when port disabled");
    chk_shift_gated: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !sel |=> $stable(sh_reg))
        else $error("input shifted while deselected");
    chk_no_sel_cnt: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        s2_reg.serial_select_n |=> cnt_reg == 5'd0)
        else $error("bit count moved while deselected");
    chk_sdo_gated: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!$stable(serial_out_line) && $past(sel)) |-> $past(fall))
        else $error("output bit changed off falling edge");
    chk_sdo_idle_low: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !sel |=> !serial_out_line)
        else $error("serial output not parked low");
    chk_oe_sel_low: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        sel |=> !serial_out_oe_n)
        else $error("serial output not driven while selected");
    chk_oe_ext_off: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !ext_mode |=> serial_out_oe_n)
        else $error("serial output driven with port disabled");
    chk_ctrl_hold: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (ext_mode && !sel) |=> $stable(ctrl_reg_out))
        else $error("control changed while deselected");

    // ****************************************
    // Pattern checks
    // ****************************************
    chk_tp_pin: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (!ext_mode && s2_reg.test_pattern_select) |=> pattern_active)
        else $error("pattern not entered from pin");
    chk_tp_ecm: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        ext_mode |=> pattern_active == $past(ctrl_reg[sptp_pkg::PATTERN_BIT]))
        else $error("pattern not following control bit");
    chk_tp_period: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        (tp_reg && tp_en) ##1 tp_en[*3] |=> data_out == $past(data_out, 4))
        else $error("pattern period not constant");
    chk_dout_conv: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !tp_en |=> data_out == $past(conv_data))
        else $error("conversion data not passed through");
    chk_tp_restart: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !tp_en |=> tp_idx_reg == 2'h0)
        else $error("pattern index not cleared when idle");
endmodule : sptp_core

`default_nettype wire

//--- verif/sptp_host.sv
// Host model driving the serial port pins
`timescale 1ns/10ps
`default_nettype none
module sptp_host (
    input wire logic ref_clk,
    input wire logic serial_out_line,
    output logic sclk,
    output logic sel_n,
    output logic serial_in_line
);
    initial {sclk, sel_n, serial_in_line} = 3'b010;
    // Clock idles low outside frames
    task automatic frame(logic [23:0] f, int n, output logic [23:0] rd);
        @(negedge ref_clk) sel_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        for (int i = 23; i > 23 - n; i--) begin
            serial_in_line = f[i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            rd = {rd[22:0], serial_out_line};
            sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        sel_n = 1'b1;
        serial_in_line = ~serial_in_line; // Line flipped after deselect, which the core must ignore
        repeat (4) @(negedge ref_clk);
    endtask : frame
endmodule : sptp_host
`default_nettype wire

//--- verif/sptp_core_test.sv
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`default_nettype none
module sptp_core_test;
    logic ref_clk = 1'b0, sys_rst = 1'b1;
    logic ext_en_n = 1'b1, tp_sel = 1'b0;
    logic [11:0] conv = 12'h3c5;
    logic sclk, sel_n, sin, sout, oe_n, pat;
    logic [11:0] dout;
    logic [15:0] ctrl;
    logic [23:0] rd;
    logic [11:0] tpw [4] = '{sptp_pkg::TP_WORD0, sptp_pkg::TP_WORD1,
        sptp_pkg::TP_WORD2, sptp_pkg::TP_WORD3};
    int failures = 0, tests_run = 0;
    always #20 ref_clk = ~ref_clk;
    sptp_host host_u (.ref_clk(ref_clk), .serial_out_line(sout),
        .sclk(sclk), .sel_n(sel_n), .serial_in_line(sin));
    sptp_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .pins({sclk, sel_n, sin, ext_en_n, tp_sel}), .conv_data(conv),
        .serial_out_line(sout), .serial_out_oe_n(oe_n), .data_out(dout),
        .pattern_active(pat), .ctrl_reg_out(ctrl));
    task automatic check(logic [23:0] seen, logic [23:0] exp);
        tests_run++;
        if (seen !== exp) failures++;
        if (seen !== exp) $display("BAD %0t %h %h", $time, seen, exp);
    endtask : check
    task automatic wrap_up();
        $display("checks %0d bad %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic t_pins();
        tp_sel = 1'b1;
        repeat (6) @(negedge ref_clk);
        check(24'(pat), 24'h1);
        repeat (4) if (dout !== tpw[0]) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            check(24'(dout), 24'(tpw[i % 4]));
            @(negedge ref_clk);
        end
        host_u.frame(24'h001000, 24, rd);
        check(24'(ctrl), 24'h0);
        check(24'(oe_n), 24'h1);
        $display("t_pins done");
    endtask : t_pins
    task automatic t_ecm();
        {ext_en_n, tp_sel} = 2'b01;
        repeat (6) @(negedge ref_clk);
        check(24'(pat), 24'h0);
        host_u.frame(24'h001abc, 24, rd);
        check(24'(pat), 24'h1);
        check(24'(oe_n), 24'h1);
        fork
            host_u.frame(24'h800000, 24, rd);
            #400 check(24'(oe_n), 24'h0);
        join
        check(24'(rd[15:0]), 24'h1abc);
        host_u.frame(24'h00ffff, 8, rd);
        host_u.frame(24'h000055, 24, rd);
        check(24'(ctrl), 24'h55);
        check(24'(pat), 24'h0);
        check(24'(dout), 24'h3c5);
        check(24'(sout), 24'h0);
        ext_en_n = 1'b1;
        repeat (6) @(negedge ref_clk);
        check(24'(ctrl), 24'h0);
        $display("t_ecm done");
    endtask : t_ecm
    initial begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_pins();
        t_ecm();
        wrap_up();
    end
    initial begin
        #200000 failures++;
        wrap_up();
    end
endmodule : sptp_core_test
`default_nettype wire
